// *** logic/asu_pkg.sv ***
// Constants, types and helpers for the asynchronous multiprocessor serial unit
// Behaviour
// - Clearing tx_on forces tx_holding_empty to 1
// - Clearing rx_on keeps receive flags and data
// - Holding full: move to shift, set empty
// - Load raises tx_empty_irq when enabled
// - Frame: start, data, extra bit, stops
// - Stop time, data waiting: chain next frame
// - Stop time, nothing waiting: done, then idle
// - tx_done_flag with enable raises tx_done_irq
// - Receiver finds start, shifts, checks parity, stop
// - Frame while full: overrun, data discarded
// - Parity mismatch: flag, data still delivered
// - Stop bit low: framing flag, data delivered
// - Any receive error with enable: error irq
// - Clean frame: deliver, set full, irq
// - Errors keep full flag; overrun loses data
// - No reception while an error flag stands
// - Station flag 1 is ID, 0 data
// - Address wait suppresses all until ID character
// - ID character: flag, clear wait, deliver
// - Multidrop format ignores parity enable
// - Transmitter sends station_flag_tx as extra bit
// - Start low, LSB first, idle high
// - 16x basic clock, sample on 8th pulse
// - Twelve formats from length, extra, stops
package asu_pkg;

  localparam int unsigned CLK_HZ    = 20_000_000;
  localparam int unsigned BAUD_RATE = 9600;
  localparam int unsigned OVS       = 16;
  localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / (OVS * BAUD_RATE) - 1);

  localparam logic [3:0] OVS_LAST  = 4'hf;
  localparam logic [3:0] SAMPLE_PT = 4'h7;
  localparam logic [2:0] LAST_BIT_8 = 3'h7;
  localparam logic [2:0] LAST_BIT_7 = 3'h6;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0c;
  localparam logic [7:0] ADDR_BAUD   = 8'h10;

  localparam int ST_TX_EMPTY   = 0;
  localparam int ST_RX_FULL    = 1;
  localparam int ST_OVERRUN    = 2;
  localparam int ST_FRAMING    = 3;
  localparam int ST_PARITY     = 4;
  localparam int ST_TX_DONE    = 5;
  localparam int ST_STATION_RX = 6;
  localparam int ST_STATION_TX = 7;

  typedef struct packed {
    logic ext_clk_sel;
    logic parity_odd;
    logic two_stop;
    logic multidrop_format_sel;
    logic parity_on;
    logic char_len_sel;
    logic address_wait_en;
    logic rx_irq_en;
    logic tx_done_irq_en;
    logic tx_empty_irq_en;
    logic rx_on;
    logic tx_on;
  } asu_ctrl_t;

  localparam int        CTRL_W   = $bits(asu_ctrl_t);
  localparam asu_ctrl_t CTRL_RST = '0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b011,
    ST_EXTRA = 3'b010,
    ST_STOP  = 3'b110
  } asu_state_t;

  function automatic logic parity_of(input logic [7:0] data, input logic len7);
    parity_of = ^(len7 ? {1'b0, data[6:0]} : data);
  endfunction : parity_of

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  sel);
    merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge16

endpackage : asu_pkg

// *** logic/asu_tick_gen.sv ***
// Basic 16x clock enable from the divisor or the external clock pin
module asu_tick_gen #(
  parameter int DIV_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ext_sel_i,
  input  wire logic [DIV_W-1:0] div_i,
  input  wire logic             ext_clk_pin_i,
  output logic                  tick_o
);

  logic [DIV_W-1:0] div_cnt_reg;
  logic             ext_meta_reg;
  logic             ext_sync_reg;
  logic             ext_prev_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= ext_clk_pin_i;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || ext_sel_i) begin
      div_cnt_reg <= '0;
    end else if (div_cnt_reg >= div_i) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + DIV_W'(1);
    end
  end

  // A stopped external clock stops the engine outright
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else if (ext_sel_i) begin
      tick_o <= ext_sync_reg & ~ext_prev_reg;
    end else begin
      tick_o <= (div_cnt_reg >= div_i);
    end
  end

endmodule : asu_tick_gen

// *** logic/asu_uart.sv ***
// Asynchronous serial unit with station-addressed receive, Wishbone slave
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
module asu_uart #(
  parameter logic [15:0] BAUD_DIV_DEFAULT = asu_pkg::BAUD_DIV_RST
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        serial_in_pin_i,
  input  wire logic        ext_clk_pin_i,
  output logic             serial_out_pin_o,
  output logic             tx_empty_irq_o,
  output logic             tx_done_irq_o,
  output logic             rx_full_irq_o,
  output logic             rx_error_irq_o
);
  import asu_pkg::*;

  asu_ctrl_t   ctrl_reg;
  logic [15:0] baud_reg;
  logic [15:0] ctrl_next;
  logic [7:0]  tx_holding_reg;
  logic [7:0]  tx_shift_reg;
  logic [7:0]  rx_holding_reg;
  logic [7:0]  rx_shift_reg;
  logic        tx_holding_empty_reg;
  logic        tx_done_reg;
  logic        rx_full_reg;
  logic        overrun_reg;
  logic        framing_reg;
  logic        parity_reg;
  logic        station_rx_reg;
  logic        station_tx_reg;
  logic [31:0] rd_data;
  logic [7:0]  status_w;
  logic [7:0]  st_clr;
  logic        acc;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_tx;
  logic        wr_baud;
  logic        tick;
  logic        len7;
  logic        has_extra;
  logic [2:0]  last_bit;

  asu_state_t  tx_state;
  logic [3:0]  tx_cnt;
  logic [2:0]  tx_bit;
  logic        tx_extra_reg;
  logic        tx_stop2_reg;
  logic        tx_pend_reg;
  logic        tx_bit_end;
  logic        tx_enter_stop;
  logic        tx_load;
  logic        tx_line;

  asu_state_t  rx_state;
  logic [3:0]  rx_cnt;
  logic [2:0]  rx_bit;
  logic        rx_meta_reg;
  logic        rx_sync_reg;
  logic        rx_prev_reg;
  logic        rx_extra_reg;
  logic        rx_sample;
  logic        rx_err;
  logic        rx_done;
  logic [7:0]  rx_data;
  logic        is_id;
  logic        accept;
  logic        ovr_ev;
  logic        fer_ev;
  logic        per_ev;
  logic        deliver;
  logic        clean;
  logic        id_clear;

  // Bus access: one wait-free answer, ack stands one cycle
  assign acc       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_ctrl   = acc & wb_we_i & (wb_adr_i == ADDR_CTRL);
  assign wr_status = acc & wb_we_i & (wb_adr_i == ADDR_STATUS) & wb_sel_i[0];
  assign wr_tx     = acc & wb_we_i & (wb_adr_i == ADDR_TXDATA) & wb_sel_i[0];
  assign wr_baud   = acc & wb_we_i & (wb_adr_i == ADDR_BAUD);
  assign st_clr    = {8{wr_status}} & ~wb_dat_i[7:0];
  assign ctrl_next = merge16(16'(ctrl_reg), wb_dat_i[15:0], wb_sel_i[1:0]);

  always_comb begin
    status_w                = '0;
    status_w[ST_TX_EMPTY]   = tx_holding_empty_reg;
    status_w[ST_RX_FULL]    = rx_full_reg;
    status_w[ST_OVERRUN]    = overrun_reg;
    status_w[ST_FRAMING]    = framing_reg;
    status_w[ST_PARITY]     = parity_reg;
    status_w[ST_TX_DONE]    = tx_done_reg;
    status_w[ST_STATION_RX] = station_rx_reg;
    status_w[ST_STATION_TX] = station_tx_reg;
  end

  always_comb begin
    unique case (wb_adr_i)
      ADDR_CTRL:   rd_data = 32'(ctrl_reg);
      ADDR_STATUS: rd_data = 32'(status_w);
      ADDR_TXDATA: rd_data = 32'(tx_holding_reg);
      ADDR_RXDATA: rd_data = 32'(rx_holding_reg);
      ADDR_BAUD:   rd_data = 32'(baud_reg);
      default:     rd_data = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc;
      if (acc) begin
        wb_dat_o <= wb_we_i ? '0 : rd_data;
      end
    end
  end

  // Software write wins over the automatic clear of address wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= asu_ctrl_t'(ctrl_next[CTRL_W-1:0]);
    end else if (id_clear) begin
      ctrl_reg.address_wait_en <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_reg <= BAUD_DIV_DEFAULT;
    end else if (wr_baud) begin
      baud_reg <= merge16(baud_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
    end
  end

  asu_tick_gen #(
    .DIV_W (16)
  ) u_tick (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ext_sel_i     (ctrl_reg.ext_clk_sel),
    .div_i         (baud_reg),
    .ext_clk_pin_i (ext_clk_pin_i),
    .tick_o        (tick)
  );

  // Frame shape
  assign len7      = ctrl_reg.char_len_sel;
  assign has_extra = ctrl_reg.multidrop_format_sel | ctrl_reg.parity_on;
  assign last_bit  = len7 ? LAST_BIT_7 : LAST_BIT_8;

  // Transmitter
  assign tx_bit_end    = tick & (tx_cnt == OVS_LAST);
  assign tx_enter_stop = tx_bit_end & (((tx_state == ST_DATA) & (tx_bit == last_bit) & ~has_extra)
                                       | (tx_state == ST_EXTRA));

  always_comb begin
    tx_load = 1'b0;
    if (ctrl_reg.tx_on && !tx_holding_empty_reg) begin
      tx_load = (tx_state == ST_IDLE) | tx_enter_stop;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_reg.tx_on) begin
      tx_state     <= ST_IDLE;
      tx_cnt       <= '0;
      tx_bit       <= '0;
      tx_stop2_reg <= 1'b0;
      tx_pend_reg  <= 1'b0;
    end else begin
      if (tick) begin
        tx_cnt <= tx_cnt + 4'h1;
      end
      unique case (tx_state)
        ST_IDLE: begin
          tx_cnt <= '0;
          if (tx_load) begin
            tx_state <= ST_START;
          end
        end
        ST_START: begin
          if (tx_bit_end) begin
            tx_state <= ST_DATA;
            tx_bit   <= '0;
          end
        end
        ST_DATA: begin
          if (tx_bit_end) begin
            if (tx_bit == last_bit) begin
              tx_state <= has_extra ? ST_EXTRA : ST_STOP;
            end else begin
              tx_bit <= tx_bit + 3'h1;
            end
          end
        end
        ST_EXTRA: begin
          if (tx_bit_end) begin
            tx_state <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tx_bit_end) begin
            if (ctrl_reg.two_stop && !tx_stop2_reg) begin
              tx_stop2_reg <= 1'b1;
            end else if (tx_pend_reg) begin
              tx_state    <= ST_START;
              tx_pend_reg <= 1'b0;
            end else begin
              tx_state <= ST_IDLE;
            end
          end
        end
        default: tx_state <= ST_IDLE;
      endcase
      if (tx_enter_stop) begin
        tx_stop2_reg <= 1'b0;
        tx_pend_reg  <= tx_load;
      end
    end
  end

  // Extra bit fixed at load so later control or station writes cannot change its value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_shift_reg <= '0;
      tx_extra_reg <= 1'b0;
    end else if (tx_load) begin
      tx_shift_reg <= tx_holding_reg;
      tx_extra_reg <= ctrl_reg.multidrop_format_sel ? station_tx_reg
                    : parity_of(tx_holding_reg, len7) ^ ctrl_reg.parity_odd;
    end else if (tx_bit_end && tx_state == ST_DATA) begin
      tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_holding_reg <= '0;
    end else if (wr_tx) begin
      tx_holding_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_holding_empty_reg <= 1'b1;
    end else if (!ctrl_reg.tx_on) begin
      tx_holding_empty_reg <= 1'b1;
    end else if (tx_load) begin
      tx_holding_empty_reg <= 1'b1;
    end else if (wr_tx) begin
      tx_holding_empty_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_done_reg <= 1'b1;
    end else if (tx_enter_stop && tx_holding_empty_reg) begin
      tx_done_reg <= 1'b1;
    end else if (wr_tx) begin
      tx_done_reg <= 1'b0;
    end
  end

  always_comb begin
    unique case (tx_state)
      ST_START: tx_line = 1'b0;
      ST_DATA:  tx_line = tx_shift_reg[0];
      ST_EXTRA: tx_line = tx_extra_reg;
      default:  tx_line = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_out_pin_o <= 1'b1;
    end else begin
      serial_out_pin_o <= tx_line;
    end
  end

  // Receiver line synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= serial_in_pin_i;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  assign rx_err    = overrun_reg | framing_reg | parity_reg;
  assign rx_sample = tick & (rx_cnt == SAMPLE_PT);

  // Returns to idle mid stop bit so the next start edge is caught unless an error flag stands
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_reg.rx_on) begin
      rx_state <= ST_IDLE;
      rx_cnt   <= '0;
      rx_bit   <= '0;
    end else begin
      if (tick) begin
        rx_cnt <= rx_cnt + 4'h1;
      end
      unique case (rx_state)
        ST_IDLE: begin
          rx_cnt <= '0;
          if (!rx_err && rx_prev_reg && !rx_sync_reg) begin
            rx_state <= ST_START;
          end
        end
        ST_START: begin
          if (rx_sample) begin
            rx_state <= rx_sync_reg ? ST_IDLE : ST_DATA;
            rx_bit   <= '0;
          end
        end
        ST_DATA: begin
          if (rx_sample) begin
            if (rx_bit == last_bit) begin
              rx_state <= has_extra ? ST_EXTRA : ST_STOP;
            end else begin
              rx_bit <= rx_bit + 3'h1;
            end
          end
        end
        ST_EXTRA: begin
          if (rx_sample) begin
            rx_state <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (rx_sample) begin
            rx_state <= ST_IDLE;
          end
        end
        default: rx_state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_shift_reg <= '0;
      rx_extra_reg <= 1'b0;
    end else if (rx_sample && rx_state == ST_DATA) begin
      rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]};
    end else if (rx_sample && rx_state == ST_EXTRA) begin
      rx_extra_reg <= rx_sync_reg;
    end
  end

  // Frame completion and error classification
  assign rx_done  = rx_sample & (rx_state == ST_STOP);
  assign rx_data  = len7 ? {1'b0, rx_shift_reg[7:1]} : rx_shift_reg;
  assign is_id    = ctrl_reg.multidrop_format_sel & rx_extra_reg;
  assign accept   = rx_done & ~(ctrl_reg.address_wait_en & ~is_id);
  assign id_clear = rx_done & ctrl_reg.address_wait_en & is_id;
  assign ovr_ev   = accept & rx_full_reg;
  assign fer_ev   = accept & ~rx_sync_reg;
  assign per_ev   = accept & ~ctrl_reg.multidrop_format_sel & ctrl_reg.parity_on
                  & (rx_extra_reg != (parity_of(rx_data, len7) ^ ctrl_reg.parity_odd));
  assign deliver  = accept & ~rx_full_reg;
  assign clean    = deliver & ~fer_ev & ~per_ev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_holding_reg <= '0;
      station_rx_reg <= 1'b0;
    end else if (deliver) begin
      rx_holding_reg <= rx_data;
      if (ctrl_reg.multidrop_format_sel) begin
        station_rx_reg <= rx_extra_reg;
      end
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_full_reg <= 1'b0;
      overrun_reg <= 1'b0;
      framing_reg <= 1'b0;
      parity_reg  <= 1'b0;
    end else begin
      if (clean) begin
        rx_full_reg <= 1'b1;
      end else if (st_clr[ST_RX_FULL]) begin
        rx_full_reg <= 1'b0;
      end
      if (ovr_ev) begin
        overrun_reg <= 1'b1;
      end else if (st_clr[ST_OVERRUN]) begin
        overrun_reg <= 1'b0;
      end
      if (fer_ev) begin
        framing_reg <= 1'b1;
      end else if (st_clr[ST_FRAMING]) begin
        framing_reg <= 1'b0;
      end
      if (per_ev) begin
        parity_reg <= 1'b1;
      end else if (st_clr[ST_PARITY]) begin
        parity_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      station_tx_reg <= 1'b0;
    end else if (wr_status) begin
      station_tx_reg <= wb_dat_i[ST_STATION_TX];
    end
  end

  // Interrupt requests are levels that follow flag and enable, the empty request only while tx_on is set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_empty_irq_o <= 1'b0;
      tx_done_irq_o  <= 1'b0;
      rx_full_irq_o  <= 1'b0;
      rx_error_irq_o <= 1'b0;
    end else begin
      tx_empty_irq_o <= ctrl_reg.tx_on & ctrl_reg.tx_empty_irq_en & tx_holding_empty_reg;
      tx_done_irq_o  <= ctrl_reg.tx_done_irq_en & tx_done_reg;
      rx_full_irq_o  <= ctrl_reg.rx_irq_en & rx_full_reg;
      rx_error_irq_o <= ctrl_reg.rx_irq_en & rx_err;
    end
  end

endmodule : asu_uart

// *** tb/asu_checker.sv ***
// Port-level assertions for the serial unit
module asu_checker
  import asu_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        serial_out_pin_o,
  input wire logic        tx_empty_irq_o,
  input wire logic        tx_done_irq_o,
  input wire logic        rx_full_irq_o,
  input wire logic        rx_error_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req;
  logic take_wr;
  logic keep_ok;
  logic tx_on_reg;
  logic done_ie_reg;
  logic rx_ie_reg;
  logic clr_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Enables shadowed at the very edge the design takes the write
  assign req     = wb_cyc_i && wb_stb_i;
  assign take_wr = req && !wb_ack_o && wb_we_i && wb_sel_i[0];
  assign keep_ok = !rx_ie_reg || clr_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {tx_on_reg, done_ie_reg, rx_ie_reg} <= 3'h0;
    end else if (take_wr && wb_adr_i == ADDR_CTRL) begin
      {tx_on_reg, done_ie_reg, rx_ie_reg} <= {wb_dat_i[0], wb_dat_i[3], wb_dat_i[4]};
    end
  end

  always_ff @(posedge clk_i) begin
    clr_reg <= !rst_i && take_wr && wb_adr_i == ADDR_STATUS;
  end

  sequence s_take;
    req && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  bus_answer_a: assert property (s_take |=> s_pulse) else $error("ack not one pulse");
  ack_cause_a: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
  reset_idle_a: assert property ($fell(rst_i) |-> serial_out_pin_o)
    else $error("line low after reset");
  // Two cycles off: the registered line still shows the aborted bit for one cycle
  tx_off_idle_a: assert property (!tx_on_reg ##1 !tx_on_reg |=> serial_out_pin_o && !tx_empty_irq_o)
    else $error("line active while transmitter off");
  // Abort by software may cut a start bit short, so it is excused
  start_low_a: assert property ($fell(serial_out_pin_o) |-> (!serial_out_pin_o || !tx_on_reg) [*8])
    else $error("start bit too short");
  done_irq_a: assert property ($rose(tx_done_irq_o) |-> $past(done_ie_reg) ##1 serial_out_pin_o)
    else $error("done request without enable or line low");
  full_irq_en_a: assert property ($rose(rx_full_irq_o) |-> $past(rx_ie_reg))
    else $error("full request without enable");
  err_irq_en_a: assert property ($rose(rx_error_irq_o) |-> $past(rx_ie_reg))
    else $error("error request without enable");
  full_keep_a: assert property ($fell(rx_full_irq_o) |-> $past(keep_ok))
    else $error("full flag lost without clear");
  err_keep_a: assert property ($fell(rx_error_irq_o) |-> $past(keep_ok))
    else $error("error flag lost without clear");
endmodule : asu_checker

// *** tb/asu_station.sv ***
// Remote serial station: frame sender and frame catcher
module asu_station (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned cyc_n = 0;
  logic [8:0]  got_q[$];
  int unsigned start_q[$];

  initial line_o = 1'b1;

  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
  end

  // Samples mid-bit at 16 clocks a bit; the divisor must be 0
  initial begin : catcher
    logic [8:0] w;
    forever begin
      do @(posedge clk_i); while (line_i !== 1'b1);
      do @(posedge clk_i); while (line_i !== 1'b0);
      start_q.push_back(cyc_n);
      repeat (8) @(posedge clk_i);
      for (int i = 0; i < 9; i++) begin
        repeat (16) @(posedge clk_i);
        w[i] = line_i;
      end
      got_q.push_back(w);
    end
  end

  task automatic send(input logic [9:0] bits, input int n);
    line_o <= 1'b0;
    repeat (16) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      line_o <= bits[i];
      repeat (16) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask : send
endmodule : asu_station

// *** tb/asu_uart_bench.sv ***
// Self-checking bench for the serial unit
module asu_uart_bench
  import asu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wd = 32'h0;
  logic [31:0] wb_rd;
  logic [31:0] st_v;
  logic        wb_ack;
  logic        rx_line;
  logic        tx_line;
  logic [3:0]  irq;
  logic        ext_ck = 1'b0;
  int          err_total = 0;
  int          num_checks = 0;

  always #25 clk_i = ~clk_i;
  // External 16x clock runs free, so it also stands during initialization
  always #100 ext_ck = ~ext_ck;

  asu_uart uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'h3), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
    .serial_in_pin_i(rx_line), .ext_clk_pin_i(ext_ck), .serial_out_pin_o(tx_line),
    .tx_empty_irq_o(irq[3]), .tx_done_irq_o(irq[2]), .rx_full_irq_o(irq[1]),
    .rx_error_irq_o(irq[0])
  );

  asu_station peer (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Leading edge wait keeps one idle cycle between cycles
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_wd  <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_rd;
    wb_cyc <= 1'b0;
    if (wb_ack !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, exp, q);
  endtask : rdc

  task automatic flags(input logic [3:0] exp);
    bus(1'b0, ADDR_STATUS, 32'h0, st_v);
    check("status flags", {28'h0, exp}, {28'h0, st_v[4:1]});
  endtask : flags

  task automatic rx_frame(input logic [7:0] d, input logic x, input logic s);
    @(posedge clk_i);
    peer.send({s, x, d}, 10);
    repeat (6) @(posedge clk_i);
  endtask : rx_frame

  task automatic wait_rx(input int n);
    int k;
    for (k = 0; k < 4000 && peer.got_q.size() < n; k++) begin
      @(posedge clk_i);
    end
    if (k >= 4000) begin
      err_total++;
      tally_and_finish();
    end
  endtask : wait_rx

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("ctrl", ADDR_CTRL, 32'h0);
    rdc("status", ADDR_STATUS, 32'h21);
    rdc("baud", ADDR_BAUD, 32'(BAUD_DIV_RST));
    rdc("unmapped", 8'h14, 32'h0);
    wr(ADDR_BAUD, 32'h0);
    wr(ADDR_CTRL, 32'h00d);
    wr(ADDR_TXDATA, 32'ha5);
    rdc("loaded", ADDR_STATUS, 32'h01);
    check("empty irq", 32'h1, {31'h0, irq[3]});
    wr(ADDR_TXDATA, 32'h3c);
    rdc("pending", ADDR_STATUS, 32'h00);
    wait_rx(2);
    check("frame 0", 32'h1a5, 32'(peer.got_q[0]));
    check("frame 1", 32'h13c, 32'(peer.got_q[1]));
    check("gap", OVS * 10, peer.start_q[1] - peer.start_q[0]);
    repeat (20) @(posedge clk_i);
    rdc("done", ADDR_STATUS, 32'h21);
    check("done irq", 32'h1, {31'h0, irq[2]});
    wr(ADDR_TXDATA, 32'h55);
    wr(ADDR_TXDATA, 32'h66);
    repeat (40) @(posedge clk_i);
    wr(ADDR_CTRL, 32'h00c);
    bus(1'b0, ADDR_STATUS, 32'h0, st_v);
    check("empty when off", 32'h1, {31'h0, st_v[0]});
    repeat (200) @(posedge clk_i);
    wr(ADDR_CTRL, 32'h141);
    wr(ADDR_STATUS, 32'h9e);
    wr(ADDR_TXDATA, 32'h81);
    wait_rx(4);
    check("id frame", 32'h181, 32'(peer.got_q[3]));
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h092);
    rx_frame(8'h5a, ^8'h5a, 1'b1);
    flags(4'h1);
    rdc("rx data", ADDR_RXDATA, 32'h5a);
    check("rx irqs", 32'h2, {30'h0, irq[1:0]});
    rx_frame(8'hc3, ^8'hc3, 1'b1);
    flags(4'h3);
    rdc("kept data", ADDR_RXDATA, 32'h5a);
    check("err irq", 32'h3, {30'h0, irq[1:0]});
    wr(ADDR_CTRL, 32'h090);
    flags(4'h3);
    rdc("rx off data", ADDR_RXDATA, 32'h5a);
    wr(ADDR_STATUS, 32'h80);
    wr(ADDR_CTRL, 32'h092);
    rx_frame(8'h33, ~^8'h33, 1'b1);
    flags(4'h8);
    rdc("parity data", ADDR_RXDATA, 32'h33);
    wr(ADDR_STATUS, 32'h80);
    rx_frame(8'h6e, ^8'h6e, 1'b0);
    flags(4'h4);
    rdc("framing data", ADDR_RXDATA, 32'h6e);
    rx_frame(8'h11, ^8'h11, 1'b1);
    rdc("blocked", ADDR_RXDATA, 32'h6e);
    wr(ADDR_STATUS, 32'h80);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h1b2);
    rx_frame(8'h24, 1'b0, 1'b0);
    flags(4'h0);
    rx_frame(8'h42, 1'b1, 1'b1);
    flags(4'h1);
    check("station bit", 32'h1, {31'h0, st_v[6]});
    rdc("id data", ADDR_RXDATA, 32'h42);
    rdc("wait cleared", ADDR_CTRL, 32'h192);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h801);
    wr(ADDR_TXDATA, 32'hff);
    for (int k = 0; k < 400 && tx_line !== 1'b0; k++) @(posedge clk_i);
    // A start bit of 16 external ticks spans 64 clocks, so mid-bit the line is still low
    repeat (40) @(posedge clk_i);
    check("ext start bit", 32'h0, {31'h0, tx_line});
    tally_and_finish();
  end
endmodule : asu_uart_bench

bind asu_uart asu_checker chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .serial_out_pin_o, .tx_empty_irq_o, .tx_done_irq_o,
  .rx_full_irq_o, .rx_error_irq_o);
